/* File: dv/rcs_checker.sv */
// Purpose: port checks for the config and status register bank
// Assumes: bound to rcs_regs, one mclk domain
// Notes: retry wait bound kept in a helper counter
`timescale 1ns/10ps
module rcs_checker #(
   parameter int STEP_CYC = 20
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic csn,
   input wire logic miso_oe,
   input wire logic irq_n,
   input wire logic [2:0] irq_mask,
   input wire logic ack_fail,
   input wire logic [1:0] address_length_code,
   input wire logic [2:0] addr_bytes,
   input wire logic [3:0] retransmit_delay,
   input wire logic [3:0] retransmit_limit,
   input wire logic [6:0] radio_channel,
   input wire logic low_rate_select,
   input wire logic high_rate_select,
   input wire logic [1:0] output_power_level,
   input wire logic [1:0] air_rate,
   input wire logic retry_go,
   input wire logic retry_wait,
   input wire logic tx_blocked
);
   localparam int WAIT_MAX = 16 * STEP_CYC + 2;
   int wait_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   always_ff @(posedge mclk) begin
      if (!rstn || !retry_wait) wait_cnt <= 0;
      else wait_cnt <= wait_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////
   sequence s_cs_idle; csn [*6]; endsequence
   sequence s_cs_busy; !csn [*4]; endsequence
   sequence s_wait_min; retry_wait [*8]; endsequence
   property p_aw_legal; address_length_code != 2'h0; endproperty
   property p_bytes; addr_bytes == ((address_length_code == 2'h1) ? 3'h3 :
      (address_length_code == 2'h2) ? 3'h4 : 3'h5); endproperty
   property p_rate; air_rate == ((low_rate_select && !high_rate_select) ?
      2'h2 : {1'b0, high_rate_select}); endproperty
   property p_oe_off; s_cs_idle |-> !miso_oe; endproperty
   property p_oe_on; s_cs_busy |-> miso_oe; endproperty
   property p_cfg_hold; s_cs_idle |-> $stable({address_length_code,
      retransmit_delay, retransmit_limit, radio_channel, low_rate_select,
      high_rate_select, output_power_level}); endproperty
   property p_irq_mask; $past(irq_mask) == 3'h7 |-> irq_n; endproperty
   property p_go; retry_go |-> $past(retry_wait); endproperty
   property p_wait_min; $rose(retry_wait) |-> s_wait_min; endproperty
   property p_wait_max; wait_cnt <= WAIT_MAX; endproperty
   property p_block; $rose(tx_blocked) |-> $past(ack_fail); endproperty
   property p_limit0; (ack_fail && retransmit_limit == 4'h0 && !retry_wait)
      |=> !retry_wait; endproperty
   a_aw_legal: assert property (p_aw_legal)
      else $error("address code zero");
   a_bytes: assert property (p_bytes)
      else $error("address byte count wrong");
   a_rate: assert property (p_rate)
      else $error("air rate wrong");
   a_oe_off: assert property (p_oe_off)
      else $error("miso driven while deselected");
   a_oe_on: assert property (p_oe_on)
      else $error("miso not driven while selected");
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("config changed outside a frame");
   a_irq_mask: assert property (p_irq_mask)
      else $error("masked flags reached irq");
   a_go: assert property (p_go)
      else $error("retry without wait");
   a_wait_min: assert property (p_wait_min)
      else $error("retry wait too short");
   a_wait_max: assert property (p_wait_max)
      else $error("retry wait too long");
   a_block: assert property (p_block)
      else $error("blocked without failed ack");
   a_limit0: assert property (p_limit0)
      else $error("retry started with limit zero");
endmodule : rcs_checker

/* File: dv/rcs_host.sv */
// Purpose: host spi master model, mode 0, msb first
// Assumes: sck 160 ns period, stands low outside frames
// Notes: got pulses once per two-byte frame
`timescale 1ns/10ps
module rcs_host (
   input wire logic mclk,
   input wire logic miso,
   output logic sck,
   output logic csn,
   output logic mosi,
   output logic got,
   output logic [7:0] got_status,
   output logic [7:0] got_data
);
   initial begin
      sck = 1'b0;
      csn = 1'b1;
      mosi = 1'b0;
      got = 1'b0;
   end
   task automatic frame(input logic [7:0] b0, input logic [7:0] b1);
      logic [15:0] tx;
      logic [15:0] rx;
      tx = {b0, b1};
      repeat (4) @(negedge mclk);
      csn = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi = tx[i];
         repeat (16) @(negedge mclk);
         rx = {rx[14:0], miso};
         sck = 1'b1;
         repeat (16) @(negedge mclk);
         sck = 1'b0;
      end
      repeat (8) @(negedge mclk);
      csn = 1'b1;
      // released line shows the inverse
      mosi = ~mosi;
      {got_status, got_data} = rx;
      got = 1'b1;
      @(negedge mclk);
      got = 1'b0;
   endtask : frame
endmodule : rcs_host

/* File: dv/tb.sv */
// Purpose: self-checking bench for the register bank
// Assumes: host model drives spi, bench drives engine events
// Notes: expected bytes are queued per frame
`timescale 1ns/10ps
module tb;
   localparam int STEP = 20;
   logic mclk = 1'b0, rstn, rx_arrived, tx_done, ack_rcvd, ack_fail;
   logic new_packet, auto_ack_on, tx_fifo_full, sck, csn, mosi, miso;
   logic miso_oe, irq_n, got, low_rate_select, high_rate_select;
   logic retry_go, retry_wait, tx_blocked, bank = 1'b0;
   logic [2:0] head_pipe, irq_mask, addr_bytes, flg = 3'h0;
   logic [7:0] got_status, got_data;
   logic [1:0] address_length_code, output_power_level, air_rate;
   logic [3:0] retransmit_delay, retransmit_limit;
   logic [6:0] radio_channel;
   logic [16:0] e;
   logic [16:0] exp_q[$];
   logic [4:0] ta[7] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h1f};
   logic [7:0] tv[7] = '{8'h03, 8'h03, 8'h02, 8'h0f, 8'h0f, 8'h00, 8'h00};
   logic [7:0] rate_tab[4] = '{8'h00, 8'h01, 8'h02, 8'h01};
   logic [7:0] ch;
   int errors = 0, total_checks = 0, seed = 69538, n;
   rcs_regs #(.STEP_CYC(STEP)) uut (.mclk, .rstn, .sck, .csn, .mosi,
      .miso, .miso_oe, .irq_n, .rx_arrived, .tx_done, .ack_rcvd, .ack_fail,
      .new_packet, .auto_ack_on, .head_pipe, .tx_fifo_full, .irq_mask,
      .address_length_code, .addr_bytes, .retransmit_delay,
      .retransmit_limit, .radio_channel, .low_rate_select,
      .high_rate_select, .output_power_level, .air_rate, .retry_go,
      .retry_wait, .tx_blocked);
   rcs_host host (.mclk, .miso, .sck, .csn, .mosi, .got, .got_status,
      .got_data);
   always #2.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [7:0] seen,
      input logic [7:0] expv);
      total_checks++;
      if (seen !== expv) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, expv, seen);
      end
   endtask : check
   task end_sim;
      if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
      input logic care, input logic [7:0] d);
      exp_q.push_back({care, bank, flg,
         (head_pipe == 3'h6) ? 3'h7 : head_pipe, tx_fifo_full, d});
      host.frame(b0, b1);
   endtask : xfer
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      xfer({rcs_pkg::CMD_WR, a}, v, 1'b0, 8'h00);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] v);
      xfer({rcs_pkg::CMD_RD, a}, 8'hff, 1'b1, v);
   endtask : rd
   task automatic nop();
      xfer(rcs_pkg::CMD_NOP, rcs_pkg::CMD_NOP, 1'b0, 8'h00);
   endtask : nop
   task automatic pulse(ref logic s);
      @(negedge mclk) s = 1'b1;
      @(negedge mclk) s = 1'b0;
      repeat (2) @(negedge mclk);
   endtask : pulse
   always @(posedge got) begin
      e = exp_q.pop_front();
      check("status", got_status, e[15:8]);
      if (e[16]) check("data", got_data, e[7:0]);
   end
   initial begin
      #400000;
      errors++;
      end_sim();
   end
   initial begin
      {rstn, rx_arrived, tx_done, ack_rcvd, ack_fail, new_packet} = 6'h00;
      {auto_ack_on, tx_fifo_full, head_pipe, irq_mask} = 8'h70;
      repeat (2) @(negedge mclk);
      rstn = 1'b1;
      repeat (6) @(negedge mclk);
      for (int i = 0; i < 7; i++) rd(ta[i], tv[i]);
      wr(rcs_pkg::ADDR_AW, 8'h00);
      rd(rcs_pkg::ADDR_AW, 8'h03);
      for (int i = 1; i < 4; i++) begin
         wr(rcs_pkg::ADDR_AW, 8'(i));
         check("bytes", {5'h0, addr_bytes}, 8'(i + 2));
      end
      for (int i = 0; i < 4; i++) begin
         wr(rcs_pkg::ADDR_RFSET, {2'h0, i[1], 1'b0, i[0], 3'h2});
         check("rate", {6'h0, air_rate}, rate_tab[i]);
      end
      check("power", {6'h0, output_power_level}, 8'h01);
      rd(rcs_pkg::ADDR_RFSET, 8'h2a);
      ch = 8'($random(seed)) & 8'h7f;
      wr(rcs_pkg::ADDR_CHAN, ch);
      rd(rcs_pkg::ADDR_CHAN, ch);
      for (int i = 0; i < 5; i++) begin
         {tx_fifo_full, head_pipe} = (i == 4) ? 4'h6 : 4'($random(seed));
         nop();
      end
      {tx_fifo_full, head_pipe} = 4'h7;
      pulse(rx_arrived);
      flg[2] = 1'b1;
      pulse(tx_done);
      flg[1] = 1'b1;
      nop();
      check("irq", {7'h0, irq_n}, 8'h00);
      irq_mask = 3'h6;
      repeat (3) @(negedge mclk);
      check("irq", {7'h0, irq_n}, 8'h01);
      wr(rcs_pkg::ADDR_STATUS, 8'h40);
      flg[2] = 1'b0;
      irq_mask = 3'h5;
      repeat (3) @(negedge mclk);
      check("irq", {7'h0, irq_n}, 8'h00);
      wr(rcs_pkg::ADDR_STATUS, 8'h20);
      flg[1] = 1'b0;
      auto_ack_on = 1'b1;
      pulse(tx_done);
      nop();
      pulse(ack_rcvd);
      flg[1] = 1'b1;
      wr(rcs_pkg::ADDR_STATUS, 8'h20);
      flg[1] = 1'b0;
      wr(rcs_pkg::ADDR_RETR, 8'h11);
      pulse(ack_fail);
      n = 3;
      while (retry_go !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      check("delay", 8'(n >= 2 * STEP && n <= 2 * STEP + 3), 8'h01);
      rd(rcs_pkg::ADDR_OBS, 8'h01);
      pulse(ack_fail);
      flg[0] = 1'b1;
      rd(rcs_pkg::ADDR_OBS, 8'h11);
      check("blocked", {7'h0, tx_blocked}, 8'h01);
      wr(rcs_pkg::ADDR_STATUS, 8'h10);
      flg[0] = 1'b0;
      check("blocked", {7'h0, tx_blocked}, 8'h00);
      wr(rcs_pkg::ADDR_CHAN, 8'h02);
      rd(rcs_pkg::ADDR_OBS, 8'h01);
      pulse(new_packet);
      rd(rcs_pkg::ADDR_OBS, 8'h00);
      wr(rcs_pkg::ADDR_RETR, 8'h00);
      repeat (17) pulse(ack_fail);
      flg[0] = 1'b1;
      rd(rcs_pkg::ADDR_OBS, 8'hf0);
      irq_mask = 3'h7;
      repeat (3) @(negedge mclk);
      check("irq", {7'h0, irq_n}, 8'h01);
      for (int i = 0; i < 2; i++) begin
         xfer(rcs_pkg::CMD_TOGGLE, rcs_pkg::TOGGLE_KEY, 1'b0, 8'h00);
         bank = ~bank;
         nop();
      end
      end_sim();
   end
endmodule : tb
bind rcs_regs rcs_checker #(.STEP_CYC(STEP_CYC)) chk (.mclk, .rstn, .csn,
   .miso_oe, .irq_n, .irq_mask, .ack_fail, .address_length_code,
   .addr_bytes, .retransmit_delay, .retransmit_limit, .radio_channel,
   .low_rate_select, .high_rate_select, .output_power_level, .air_rate,
   .retry_go, .retry_wait, .tx_blocked);

/* File: rtl/rcs_delay_timer.sv */
// Purpose: retransmit delay timer
// Assumes: start is a one-cycle pulse
// Notes: expires after (code+1) steps of 250 us
`timescale 1ns/10ps
module rcs_delay_timer #(
   parameter int STEP_CYC = rcs_pkg::DELAY_STEP_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [3:0] code,
   output logic busy,
   output logic expire
);
   logic [15:0] tick;
   logic [4:0] steps;
   wire step_end = (tick == 16'(STEP_CYC - 1));

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tick <= 16'h0000;
         steps <= 5'h00;
         busy <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (start) begin
            tick <= 16'h0000;
            steps <= {1'b0, code} + 5'h01;
            busy <= 1'b1;
         end else if (busy) begin
            tick <= step_end ? 16'h0000 : tick + 16'h0001;
            if (step_end) begin
               steps <= steps - 5'h01;
               if (steps == 5'h01) begin
                  busy <= 1'b0;
                  expire <= 1'b1;
               end
            end
         end
      end
   end
endmodule : rcs_delay_timer

/* File: rtl/rcs_pkg.sv */
// Purpose: constants for the radio configuration and status register bank
// Assumes: byte-wide spi frames, msb first, spi mode 0
// Notes: offsets are bank 0 register addresses
//
// Overview of operation
// - address_length_code selects 3, 4 or 5 byte addresses; 00 illegal; resets 11.
// - shorter widths use only the low bytes of stored addresses.
// - retransmit_delay waits 250 us per step, 250 us up to 4000 us.
// - retransmit_limit caps retries after failed ack; zero disables; resets 0011.
// - radio_channel is seven bits, resets to 2, top bit written zero.
// - low and high rate bits pick 1M, 2M, 250K, 2M; reset is 2M.
// - output_power_level at bits 2:1 of radio_setup, resets to 11.
// - status shifts out on miso while each command byte shifts in.
// - bank_indicator at bit 7 shows the bank; toggled by command plus 0x53.
// - receive_data_ready_flag at bit 6 set on new rx data, write one clears.
// - data_sent_flag at bit 5 set on sent packet, or on ack when enabled.
// - retry_limit_flag at bit 4 set at limit; must be cleared to continue.
// - pipe number at bits 3:1 shows head pipe; 111 means rx fifo empty.
// - transmit fifo full flag at bit 0 reads one when full.
// - lost_packet_counter at bits 7:4 counts lost packets, saturating at 15.
// - any write to radio_channel clears the lost packet counter.
// - retransmission_counter at bits 3:0 counts retries, cleared on new packet.
// - unmasked set flags drive the active-low interrupt pin low.
package rcs_pkg;
   localparam logic [4:0] ADDR_AW = 5'h03;
   localparam logic [4:0] ADDR_RETR = 5'h04;
   localparam logic [4:0] ADDR_CHAN = 5'h05;
   localparam logic [4:0] ADDR_RFSET = 5'h06;
   localparam logic [4:0] ADDR_STATUS = 5'h07;
   localparam logic [4:0] ADDR_OBS = 5'h08;
   localparam logic [1:0] RST_AW = 2'h3;
   localparam logic [7:0] RST_RETR = 8'h03;
   localparam logic [6:0] RST_CHAN = 7'h02;
   localparam logic [5:0] RST_RFSET = 6'h0f;
   localparam logic [2:0] PIPE_EMPTY = 3'h7;
   localparam logic [3:0] CNT_MAX = 4'hf;
   // spi commands
   localparam logic [2:0] CMD_RD = 3'h0;
   localparam logic [2:0] CMD_WR = 3'h1;
   localparam logic [7:0] CMD_TOGGLE = 8'h50;
   localparam logic [7:0] TOGGLE_KEY = 8'h53;
   localparam logic [7:0] CMD_NOP = 8'hff;
   // status bit positions
   localparam int BIT_BANK = 7;
   localparam int BIT_RXDR = 6;
   localparam int BIT_TXDS = 5;
   localparam int BIT_MAXRT = 4;
   localparam int BIT_TXFULL = 0;
   // retransmit delay
   localparam int DELAY_STEP_US = 250;
   localparam int CLK_MHZ = 200;
   localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
   typedef enum logic [1:0] {
      RCS_IDLE = 2'b00,
      RCS_DATA = 2'b01,
      RCS_KEY = 2'b10,
      RCS_SKIP = 2'b11
   } rcs_frame_t;
endpackage : rcs_pkg

/* File: rtl/rcs_regs.sv */
// Purpose: bank 0 config and status registers 03..08 behind spi
// Assumes: packet engine gives one-cycle event pulses on mclk
// Notes: spi pins pass two flops inside the shifter
`timescale 1ns/10ps
module rcs_regs #(
   parameter int STEP_CYC = rcs_pkg::DELAY_STEP_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic csn,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   output logic irq_n,
   input wire logic rx_arrived,
   input wire logic tx_done,
   input wire logic ack_rcvd,
   input wire logic ack_fail,
   input wire logic new_packet,
   input wire logic auto_ack_on,
   input wire logic [2:0] head_pipe,
   input wire logic tx_fifo_full,
   input wire logic [2:0] irq_mask,
   output logic [1:0] address_length_code,
   output logic [2:0] addr_bytes,
   output logic [3:0] retransmit_delay,
   output logic [3:0] retransmit_limit,
   output logic [6:0] radio_channel,
   output logic low_rate_select,
   output logic high_rate_select,
   output logic [1:0] output_power_level,
   output logic [1:0] air_rate,
   output logic retry_go,
   output logic retry_wait,
   output logic tx_blocked
);
   ////////////////////////////////////////////////////////////////////////
   // spi front end
   logic [7:0] status;
   logic byte_done, frame_start, frame_active;
   logic [7:0] rx_byte;
   logic [7:0] load_byte;

   rcs_spi_shift u_shift (
      .mclk(mclk),
      .rstn(rstn),
      .sck(sck),
      .csn(csn),
      .mosi(mosi),
      .load_byte(load_byte),
      .miso(miso),
      .miso_oe(miso_oe),
      .frame_start(frame_start),
      .frame_active(frame_active),
      .byte_done(byte_done),
      .rx_byte(rx_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // frame decode
   rcs_pkg::rcs_frame_t state, next_state;
   logic first_byte;
   logic is_write;
   logic [4:0] reg_addr;
   logic [7:0] rd_data;

   wire cmd_rd = byte_done & first_byte & (rx_byte[7:5] == rcs_pkg::CMD_RD);
   wire cmd_wr = byte_done & first_byte & (rx_byte[7:5] == rcs_pkg::CMD_WR);
   wire cmd_tog = byte_done & first_byte & (rx_byte == rcs_pkg::CMD_TOGGLE);
   wire data_byte = byte_done & (state == rcs_pkg::RCS_DATA);
   wire wr_strobe = data_byte & is_write;
   wire key_ok = byte_done & (state == rcs_pkg::RCS_KEY) &
                 (rx_byte == rcs_pkg::TOGGLE_KEY);
   wire wr_aw = wr_strobe & (reg_addr == rcs_pkg::ADDR_AW);
   wire wr_retr = wr_strobe & (reg_addr == rcs_pkg::ADDR_RETR);
   wire wr_chan = wr_strobe & (reg_addr == rcs_pkg::ADDR_CHAN);
   wire wr_rfset = wr_strobe & (reg_addr == rcs_pkg::ADDR_RFSET);
   wire wr_stat = wr_strobe & (reg_addr == rcs_pkg::ADDR_STATUS);

   // status first, then read data on each later byte
   assign load_byte = (state == rcs_pkg::RCS_DATA && !is_write &&
                       !first_byte) ? rd_data : status;

   always_comb begin
      next_state = state;
      if (cmd_rd || cmd_wr) begin
         next_state = rcs_pkg::RCS_DATA;
      end else if (cmd_tog) begin
         next_state = rcs_pkg::RCS_KEY;
      end else if (byte_done && first_byte) begin
         next_state = rcs_pkg::RCS_SKIP;
      end else if (byte_done && state == rcs_pkg::RCS_KEY) begin
         next_state = rcs_pkg::RCS_SKIP;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn || !frame_active) begin
         state <= rcs_pkg::RCS_IDLE;
         first_byte <= 1'b1;
      end else begin
         state <= next_state;
         if (byte_done) begin
            first_byte <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         is_write <= 1'b0;
         reg_addr <= 5'h00;
      end else if (cmd_rd || cmd_wr) begin
         is_write <= cmd_wr;
         reg_addr <= rx_byte[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic bank;
   logic rx_gain_high;
   logic rx_flag, tx_flag, rt_flag;
   logic [3:0] lost_cnt, retry_cnt;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         address_length_code <= rcs_pkg::RST_AW;
         {retransmit_delay, retransmit_limit} <= rcs_pkg::RST_RETR;
         radio_channel <= rcs_pkg::RST_CHAN;
         low_rate_select <= rcs_pkg::RST_RFSET[5];
         high_rate_select <= rcs_pkg::RST_RFSET[3];
         output_power_level <= rcs_pkg::RST_RFSET[2:1];
         rx_gain_high <= rcs_pkg::RST_RFSET[0];
      end else begin
         if (wr_aw && rx_byte[1:0] != 2'h0) begin
            address_length_code <= rx_byte[1:0];
         end
         if (wr_retr) begin
            {retransmit_delay, retransmit_limit} <= rx_byte;
         end
         if (wr_chan) begin
            radio_channel <= rx_byte[6:0];
         end
         if (wr_rfset) begin
            low_rate_select <= rx_byte[5];
            high_rate_select <= rx_byte[3];
            output_power_level <= rx_byte[2:1];
            rx_gain_high <= rx_byte[0];
         end
      end
   end

   // byte count: low bytes of stored address used
   assign addr_bytes = {1'b0, address_length_code} + 3'h2;

   // 0 = 1M, 1 = 2M, 2 = 250K
   assign air_rate = low_rate_select ? (high_rate_select ? 2'h1 : 2'h2) :
                     (high_rate_select ? 2'h1 : 2'h0);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         bank <= 1'b0;
      end else if (key_ok) begin
         bank <= ~bank;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky flags: set wins over write-one clear
   wire tx_event = auto_ack_on ? ack_rcvd : tx_done;
   wire limit_hit = ack_fail & (retry_cnt >= retransmit_limit);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_flag <= 1'b0;
         tx_flag <= 1'b0;
         rt_flag <= 1'b0;
      end else begin
         rx_flag <= rx_arrived |
                    (rx_flag & ~(wr_stat & rx_byte[rcs_pkg::BIT_RXDR]));
         tx_flag <= tx_event |
                    (tx_flag & ~(wr_stat & rx_byte[rcs_pkg::BIT_TXDS]));
         rt_flag <= limit_hit |
                    (rt_flag & ~(wr_stat & rx_byte[rcs_pkg::BIT_MAXRT]));
      end
   end

   assign tx_blocked = rt_flag;

   assign status = {bank, rx_flag, tx_flag, rt_flag,
                    (head_pipe == 3'h6) ? rcs_pkg::PIPE_EMPTY : head_pipe,
                    tx_fifo_full};

   ////////////////////////////////////////////////////////////////////////
   // transmit observation counters
   always_ff @(posedge mclk) begin
      if (!rstn || wr_chan) begin
         lost_cnt <= 4'h0;
      end else if (limit_hit && lost_cnt != rcs_pkg::CNT_MAX) begin
         lost_cnt <= lost_cnt + 4'h1;
      end
   end

   wire retry_due = ack_fail & ~limit_hit & (retransmit_limit != 4'h0);

   always_ff @(posedge mclk) begin
      if (!rstn || new_packet) begin
         retry_cnt <= 4'h0;
      end else if (retry_go && retry_cnt != rcs_pkg::CNT_MAX) begin
         retry_cnt <= retry_cnt + 4'h1;
      end
   end

   rcs_delay_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .start(retry_due),
      .code(retransmit_delay),
      .busy(retry_wait),
      .expire(retry_go)
   );

   ////////////////////////////////////////////////////////////////////////
   // register read mux and interrupt pin
   always_comb begin
      unique case (reg_addr)
         rcs_pkg::ADDR_AW: rd_data = {6'h00, address_length_code};
         rcs_pkg::ADDR_RETR: rd_data = {retransmit_delay, retransmit_limit};
         rcs_pkg::ADDR_CHAN: rd_data = {1'b0, radio_channel};
         rcs_pkg::ADDR_RFSET: rd_data = {2'h0, low_rate_select, 1'b0,
                                         high_rate_select, output_power_level,
                                         rx_gain_high};
         rcs_pkg::ADDR_STATUS: rd_data = status;
         rcs_pkg::ADDR_OBS: rd_data = {lost_cnt, retry_cnt};
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~((rx_flag & ~irq_mask[2]) | (tx_flag & ~irq_mask[1]) |
                    (rt_flag & ~irq_mask[0]));
      end
   end
endmodule : rcs_regs

/* File: rtl/rcs_spi_shift.sv */
// Purpose: spi byte shifter sampled on mclk
// Assumes: mode 0, msb first, pins synchronised here
// Notes: byte_done pulses after the eighth rising sck edge
`timescale 1ns/10ps
module rcs_spi_shift (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic csn,
   input wire logic mosi,
   input wire logic [7:0] load_byte,
   output logic miso,
   output logic miso_oe,
   output logic frame_start,
   output logic frame_active,
   output logic byte_done,
   output logic [7:0] rx_byte
);
   logic [1:0] sck_m, csn_m, mosi_m;
   logic sck_d, csn_d;
   logic [2:0] bit_cnt;
   logic [7:0] shreg, txreg;
   wire sck_s = sck_m[1];
   wire csn_s = csn_m[1];
   wire mosi_s = mosi_m[1];
   wire rise = sck_s & ~sck_d;
   wire fall = ~sck_s & sck_d;
   wire start = ~csn_s & csn_d;
   wire [7:0] next_shreg = {shreg[6:0], mosi_s};

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sck_m <= 2'h0;
         csn_m <= 2'h3;
         mosi_m <= 2'h0;
      end else begin
         sck_m <= {sck_m[0], sck};
         csn_m <= {csn_m[0], csn};
         mosi_m <= {mosi_m[0], mosi};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sck_d <= 1'b0;
         csn_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
         csn_d <= csn_s;
      end
   end

   assign frame_start = start;
   assign frame_active = ~csn_s;
   // strobe registered so it lines up with rx_byte
   wire last_rise = ~csn_s & rise & (bit_cnt == 3'h7);

   always_ff @(posedge mclk) begin
      if (!rstn || csn_s) begin
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 3'h1;
         shreg <= next_shreg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_byte <= 8'h00;
         byte_done <= 1'b0;
      end else begin
         byte_done <= last_rise;
         if (last_rise) begin
            rx_byte <= next_shreg;
         end
      end
   end

   // first bit out at frame start, later bits on falling sck
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         txreg <= 8'h00;
         miso <= 1'b0;
      end else if (start || (fall && bit_cnt == 3'h0 && !csn_s)) begin
         txreg <= {load_byte[6:0], 1'b0};
         miso <= load_byte[7];
      end else if (fall && !csn_s) begin
         txreg <= {txreg[6:0], 1'b0};
         miso <= txreg[7];
      end
   end

   assign miso_oe = ~csn_s;
endmodule : rcs_spi_shift
